/* File: hazard_barrier_regs.vh */
// constants for the hazard barrier and exception return unit
`ifndef HAZARD_BARRIER_REGS_VH
`define HAZARD_BARRIER_REGS_VH
`define ADDR_CONTROL 8'h00
`define ADDR_STATUS_WORD 8'h04
`define ADDR_EXCEPTION_PC 8'h08
`define ADDR_ERROR_PC 8'h0c
`define ADDR_SHADOW_CTL 8'h10
`define ADDR_CONFIGURATION_REG_FIVE 8'h14
`define ADDR_EVENT 8'h18
`define ADDR_TARGET 8'h1c
`define ADDR_INSTR 8'h20
`define ADDR_RESULT 8'h24
`define STATUS_IE_BIT 0
`define STATUS_EXL_BIT 1
`define STATUS_ERL_BIT 2
`define STATUS_BEV_BIT 22
`define STATUS_CU0_BIT 28
`define CONFIGURATION_REG_FIVE_LLB_BIT 4
`define STATUS_RESET 32'h00400004
`define SHADOW_RESET 32'h00000000
`define CTRL_RESET 32'h00000206
`define EHB_WORD 32'h00001800
`define EI_MINOR 10'h15d
`define EXCEPTION_RETURN_MINOR 10'h3cd
`define POOL_AXF 6'h3c
`define EXC_NONE 2'h0
`define EXC_CPU 2'h1
`define EXC_RI 2'h2
`define HAZARD_DRAIN_CYCLES 4
`endif

/* File: hazard_drain.v */
// counter that holds issue until execution hazards drain
`timescale 1ns/10ps
module hazard_drain #(
   parameter DEPTH = 4
) (
   input wire aclk,
   input wire aresetn,
   input wire start,
   input wire hazard_pending,
   output wire busy
);
   reg [3:0] cnt_q;
   reg [3:0] cnt_d;
   always @* begin
      cnt_d = cnt_q;
      if (start) begin
         cnt_d = DEPTH[3:0];
      end else if (cnt_q != 4'h0 && !hazard_pending) begin
         cnt_d = cnt_q - 4'h1;
      end
   end
   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= 4'h0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
   assign busy = (cnt_q != 4'h0);
endmodule // hazard_drain

/* File: hazard_barrier_exception_return.v */
// hazard barrier, interrupt enable and exception return unit with axi4-lite registers
// How it works
// - barrier decodes as shift of register zero by three, amount in bits 15..11
// - barrier stalls issue until every older execution hazard has drained
// - barrier leaves instruction hazards; only barrier jumps and returns clear them
// - on superscalar cores barrier issues exactly like the superscalar no-op
// - revision 1 cores treat the barrier as a superscalar no-op
// - enable-interrupts writes sign-extended status to destination, then sets enable bit
// - with no register named, destination is register zero and the value is lost
// - enable-interrupts without coprocessor 0 access raises coprocessor unusable
// - before revision 2 enable-interrupts raises reserved instruction
// - status read and enable-bit set happen as one indivisible update
// - returns resume at the interrupted instruction and execute nothing after them
// - exception return clears the load-linked flag so a later conditional store fails
// - rev 2+: current shadow set takes previous if highest nonzero, boot and error zero
// - returns clear execution and instruction hazards from the fetch at the target
// - keep-link return equals exception return but leaves the load-linked flag
// - configuration register five shows link bit support for the keep-link return
//
// The implementer's own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "hazard_barrier_regs.vh"
module hazard_barrier_exception_return #(
   parameter ARCH_REV = 6,
   parameter SUPERSCALAR = 1,
   parameter HAS_COMPRESSED = 1,
   parameter HAS_KEEP_LINK = 1,
   parameter DRAIN_DEPTH = `HAZARD_DRAIN_CYCLES
) (
   input wire aclk,
   input wire aresetn,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] instr,
   input wire instr_valid,
   output wire instr_ready,
   input wire hazard_pending,
   input wire load_linked_set,
   output reg [31:0] gpr_wdata,
   output reg [4:0] gpr_waddr,
   output reg gpr_we,
   output reg [31:0] redirect_pc,
   output reg redirect,
   output reg [1:0] exc_code,
   output reg exc_valid,
   output wire issue_stall,
   output reg clear_exec_hazards,
   output reg clear_instr_hazards,
   output reg superscalar_nop_issue,
   output wire load_linked_flag,
   output wire interrupt_enable_bit,
   output wire instruction_set_mode
);
   ////////////////////////////////////////////////////////////////////////////////
   // registers
   reg [31:0] status_q;
   reg [31:0] exception_pc_q;
   reg [31:0] error_pc_q;
   reg [31:0] shadow_set_control_q;
   reg load_linked_q;
   reg isa_mode_q;
   reg [31:0] event_q;
   reg [31:0] result_q;
   reg [31:0] last_instr_q;
   reg [31:0] ctrl_q;
   reg [7:0] awaddr_q;
   reg aw_full_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg w_full_q;
   wire drain_busy;
   wire [31:0] configuration_reg_five = {27'h0, (HAS_KEEP_LINK != 0), 4'h0};
   ////////////////////////////////////////////////////////////////////////////////
   // decode
   wire is_axf = (instr[31:26] == 6'h00) && (instr[5:0] == `POOL_AXF);
   wire is_ehb = (instr == `EHB_WORD);
   wire is_ei = is_axf && (instr[15:6] == `EI_MINOR) && (instr[25:21] == 5'h00);
   wire is_exception_return = is_axf && (instr[15:6] == `EXCEPTION_RETURN_MINOR) && (instr[25:16] == 10'h000);
   wire is_exception_return_keep_link = is_axf && (instr[15:6] == `EXCEPTION_RETURN_MINOR) && (instr[25:16] == 10'h001)
      && (HAS_KEEP_LINK != 0);
   wire cu0_ok = status_q[`STATUS_CU0_BIT] | ctrl_q[0];
   wire is_ret = is_exception_return | is_exception_return_keep_link;
   wire fire = instr_valid & instr_ready;
   // a new barrier waits for the previous drain to finish
   assign instr_ready = !drain_busy;
   assign issue_stall = drain_busy;
   assign load_linked_flag = load_linked_q;
   assign interrupt_enable_bit = status_q[`STATUS_IE_BIT];
   assign instruction_set_mode = isa_mode_q;
   hazard_drain #(
      .DEPTH(DRAIN_DEPTH)
   ) u_drain (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(fire & is_ehb & (ARCH_REV >= 2)),
      .hazard_pending(hazard_pending),
      .busy(drain_busy)
   );
   wire error_level_bit = status_q[`STATUS_ERL_BIT];
   wire [31:0] ret_target = error_level_bit ? error_pc_q : exception_pc_q;
   wire compressed = (HAS_COMPRESSED != 0) | ctrl_q[1];
   wire shadow_copy = (ARCH_REV >= 2) && !error_level_bit && (shadow_set_control_q[29:26] != 4'h0)
      && !status_q[`STATUS_BEV_BIT];
   ////////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave: address and data may arrive in either order
   wire do_write = aw_full_q & w_full_q & !s_axi_bvalid;
   assign s_axi_awready = !aw_full_q;
   assign s_axi_wready = !w_full_q;
   assign s_axi_arready = !s_axi_rvalid;
   wire wr_status = do_write && awaddr_q == `ADDR_STATUS_WORD;
   wire wr_epc = do_write && awaddr_q == `ADDR_EXCEPTION_PC;
   wire wr_errpc = do_write && awaddr_q == `ADDR_ERROR_PC;
   wire wr_shadow = do_write && awaddr_q == `ADDR_SHADOW_CTL;
   wire wr_ctrl = do_write && awaddr_q == `ADDR_CONTROL;
   wire wr_event = do_write && awaddr_q == `ADDR_EVENT;
   wire wr_hit = wr_status | wr_epc | wr_errpc | wr_shadow | wr_ctrl | wr_event
      | (do_write && awaddr_q == `ADDR_CONFIGURATION_REG_FIVE);
   wire [31:0] wmask;
   genvar bi;
   generate
      for (bi = 0; bi < 4; bi = bi + 1) begin : g_lane
         assign wmask[8*bi+7:8*bi] = {8{wstrb_q[bi]}};
      end
   endgenerate
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [31:0] m;
      begin
         merge = (old & ~m) | (nw & m);
      end
   endfunction
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= 2'h0;
         s_axi_rdata <= 32'h00000000;
      end else begin
         if (s_axi_awvalid && !aw_full_q) begin
            aw_full_q <= 1'b1;
            awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && !w_full_q) begin
            w_full_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? 2'h0 : 2'h2;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case ({s_axi_araddr[7:2], 2'b00})
               `ADDR_CONTROL: s_axi_rdata <= ctrl_q;
               `ADDR_STATUS_WORD: s_axi_rdata <= status_q;
               `ADDR_EXCEPTION_PC: s_axi_rdata <= exception_pc_q;
               `ADDR_ERROR_PC: s_axi_rdata <= error_pc_q;
               `ADDR_SHADOW_CTL: s_axi_rdata <= shadow_set_control_q;
               `ADDR_CONFIGURATION_REG_FIVE: s_axi_rdata <= configuration_reg_five;
               `ADDR_EVENT: s_axi_rdata <= event_q;
               `ADDR_TARGET: s_axi_rdata <= {ret_target[31:1], ret_target[0] & !compressed};
               `ADDR_INSTR: s_axi_rdata <= last_instr_q;
               `ADDR_RESULT: s_axi_rdata <= result_q;
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // execution: one instruction per accepted cycle, status updated in one edge
   always @(posedge aclk) begin
      if (!aresetn) begin
         status_q <= `STATUS_RESET;
         exception_pc_q <= 32'h00000000;
         error_pc_q <= 32'h00000000;
         shadow_set_control_q <= `SHADOW_RESET;
         ctrl_q <= `CTRL_RESET;
         isa_mode_q <= 1'b0;
         event_q <= 32'h00000000;
         result_q <= 32'h00000000;
         last_instr_q <= 32'h00000000;
         gpr_wdata <= 32'h00000000;
         gpr_waddr <= 5'h00;
         gpr_we <= 1'b0;
         redirect_pc <= 32'h00000000;
         redirect <= 1'b0;
         exc_code <= `EXC_NONE;
         exc_valid <= 1'b0;
         clear_exec_hazards <= 1'b0;
         clear_instr_hazards <= 1'b0;
         superscalar_nop_issue <= 1'b0;
      end else begin
         gpr_we <= 1'b0;
         redirect <= 1'b0;
         exc_valid <= 1'b0;
         clear_exec_hazards <= 1'b0;
         clear_instr_hazards <= 1'b0;
         superscalar_nop_issue <= 1'b0;
         if (wr_status) status_q <= merge(status_q, wdata_q, wmask);
         if (wr_epc) exception_pc_q <= merge(exception_pc_q, wdata_q, wmask);
         if (wr_errpc) error_pc_q <= merge(error_pc_q, wdata_q, wmask);
         if (wr_shadow) shadow_set_control_q <= merge(shadow_set_control_q, wdata_q, wmask);
         if (wr_ctrl) ctrl_q <= merge(ctrl_q, wdata_q, wmask);
         // event bits clear on write of one; a new event in the same cycle wins
         if (wr_event) event_q <= event_q & ~(wdata_q & wmask);
         if (fire) begin
            last_instr_q <= instr;
            if (is_ehb) begin
               // barrier issues like the superscalar no-op; no instruction hazard clear
               superscalar_nop_issue <= (SUPERSCALAR != 0) || (ARCH_REV < 2);
               clear_exec_hazards <= (ARCH_REV >= 2);
               event_q[0] <= 1'b1;
            end else if (is_ei && ARCH_REV < 2) begin
               exc_valid <= 1'b1;
               exc_code <= `EXC_RI;
               event_q[3] <= 1'b1;
            end else if ((is_ei || is_ret) && !cu0_ok) begin
               exc_valid <= 1'b1;
               exc_code <= `EXC_CPU;
               event_q[3] <= 1'b1;
            end else if (is_ei) begin
               // read and set share one edge, so nothing can land between them
               status_q[`STATUS_IE_BIT] <= 1'b1;
               result_q <= status_q;
               gpr_wdata <= status_q;
               gpr_waddr <= instr[20:16];
               gpr_we <= (instr[20:16] != 5'h00);
               event_q[1] <= 1'b1;
            end else if (is_ret) begin
               if (error_level_bit) begin
                  status_q[`STATUS_ERL_BIT] <= 1'b0;
               end else begin
                  status_q[`STATUS_EXL_BIT] <= 1'b0;
                  if (shadow_copy) begin
                     shadow_set_control_q[3:0] <= shadow_set_control_q[9:6];
                  end
               end
               if (compressed) begin
                  redirect_pc <= {ret_target[31:1], 1'b0};
                  isa_mode_q <= ret_target[0];
               end else begin
                  redirect_pc <= ret_target;
               end
               redirect <= 1'b1;
               clear_exec_hazards <= 1'b1;
               clear_instr_hazards <= 1'b1;
               event_q[2] <= 1'b1;
            end
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // link flag apart: a load-linked in the same cycle as a return clear wins
   always @(posedge aclk) begin
      if (!aresetn) begin
         load_linked_q <= 1'b0;
      end else if (load_linked_set) begin
         load_linked_q <= 1'b1;
      end else if (fire && is_exception_return && cu0_ok) begin
         // the keep-link return never gets here, so a pending conditional store survives
         load_linked_q <= 1'b0;
      end
   end
endmodule // hazard_barrier_exception_return

/* File: hbr_props.sv */
// concurrent checks on the ports of the hazard barrier and exception return unit
`timescale 1ns/10ps
`include "hazard_barrier_regs.vh"
module hbr_props #(
   parameter ARCH_REV = 6
) (
   input wire aclk,
   input wire aresetn,
   input wire [31:0] instr,
   input wire instr_valid,
   input wire instr_ready,
   input wire load_linked_set,
   input wire gpr_we,
   input wire [4:0] gpr_waddr,
   input wire [31:0] redirect_pc,
   input wire redirect,
   input wire exc_valid,
   input wire issue_stall,
   input wire clear_exec_hazards,
   input wire clear_instr_hazards,
   input wire superscalar_nop_issue,
   input wire load_linked_flag,
   input wire interrupt_enable_bit
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire fire = instr_valid && instr_ready;
   ////////////////////////////////////////////////////////////////////////////////
   AST_STALL_READY: assert property (issue_stall |-> !instr_ready)
      else $error("instruction taken while barrier drains");
   AST_BARRIER_STALL: assert property (
      fire && instr == `EHB_WORD && ARCH_REV >= 2 |=> issue_stall)
      else $error("barrier did not stall issue");
   AST_BARRIER_CLR: assert property (fire && instr == `EHB_WORD |=>
      clear_exec_hazards == (ARCH_REV >= 2) && superscalar_nop_issue && !clear_instr_hazards)
      else $error("barrier pulses wrong hazard outputs");
   AST_RET_CLR: assert property (redirect |-> clear_exec_hazards && clear_instr_hazards)
      else $error("return without hazard clear");
   AST_RET_EVEN: assert property (redirect |-> !redirect_pc[0])
      else $error("return target has bit 0 set");
   AST_RET_CLEAR_LINK: assert property (
      redirect && !$past(instr[16]) && !$past(load_linked_set) |-> !load_linked_flag)
      else $error("plain return kept the link flag");
   // keep-link only holds a flag that was already set; it never creates one
   AST_RET_KEEP_LINK: assert property (
      redirect && $past(instr[16]) && $past(load_linked_flag) |-> load_linked_flag)
      else $error("keep-link return lost the link flag");
   AST_EXC_NOEXEC: assert property (exc_valid |-> !redirect && !gpr_we)
      else $error("faulting instruction still took effect");
   AST_EI_DEST: assert property (gpr_we |-> gpr_waddr != 5'h00)
      else $error("register zero written");
   AST_EI_IE: assert property (gpr_we |-> ##[0:1] interrupt_enable_bit)
      else $error("enable bit not set after status read");
endmodule // hbr_props

/* File: testbench.sv */
// self-checking bench for the hazard barrier and exception return unit
`timescale 1ns/10ps
`include "hazard_barrier_regs.vh"
module testbench;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, instr_valid;
   logic instr_ready, hazard_pending, load_linked_set, gpr_we, redirect, exc_valid, issue_stall;
   logic clear_exec_hazards, clear_instr_hazards, superscalar_nop_issue, load_linked_flag;
   logic interrupt_enable_bit, instruction_set_mode, g_we;
   logic r1_exv, r1_ssn, r1_ceh, r1_stall;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, instr, gpr_wdata, redirect_pc, rd, g_pc, g_gpr, seed;
   logic [31:0] st, t;
   logic [3:0] s_axi_wstrb, previous_shadow_set;
   logic [1:0] s_axi_bresp, s_axi_rresp, exc_code, g_exc, rr, r1_exc, g_r1, br;
   logic [4:0] gpr_waddr, rt, g_wa;
   int n_errors, n_compared, cyc, n;
   hazard_barrier_exception_return dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .instr, .instr_valid, .instr_ready,
      .hazard_pending, .load_linked_set, .gpr_wdata, .gpr_waddr, .gpr_we, .redirect_pc,
      .redirect, .exc_code, .exc_valid, .issue_stall, .clear_exec_hazards, .clear_instr_hazards,
      .superscalar_nop_issue, .load_linked_flag, .interrupt_enable_bit, .instruction_set_mode);
   // a revision 1 core on the same stimulus: barrier as superscalar no-op, enable-interrupts refused
   hazard_barrier_exception_return #(.ARCH_REV(1)) dut_r1 (.aclk, .aresetn, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(),
      .s_axi_rready, .instr, .instr_valid, .instr_ready(), .hazard_pending, .load_linked_set,
      .gpr_wdata(), .gpr_waddr(), .gpr_we(), .redirect_pc(), .redirect(), .exc_code(r1_exc),
      .exc_valid(r1_exv), .issue_stall(r1_stall), .clear_exec_hazards(r1_ceh),
      .clear_instr_hazards(), .superscalar_nop_issue(r1_ssn), .load_linked_flag(),
      .interrupt_enable_bit(), .instruction_set_mode());
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [31:0] ei_w(input logic [4:0] r);
      return {11'h000, r, `EI_MINOR, `POOL_AXF};
   endfunction
   function automatic logic [31:0] ret_w(input logic k);
      return {15'h0000, k, `EXCEPTION_RETURN_MINOR, `POOL_AXF};
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // each channel is released only at the edge where its own ready was seen high
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic ah, wh, bh;
      bh = 0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      while (!bh) begin
         @(negedge aclk);
         ah = s_axi_awvalid && s_axi_awready;
         wh = s_axi_wvalid && s_axi_wready;
         bh = s_axi_bvalid;
         br = s_axi_bresp;
         @(posedge aclk);
         if (ah) s_axi_awvalid <= 0;
         if (wh) s_axi_wvalid <= 0;
      end
      s_axi_bready <= 0;
   endtask
   task automatic axr(input logic [7:0] a);
      logic ah, h;
      h = 0;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      while (!h) begin
         @(negedge aclk);
         ah = s_axi_arvalid && s_axi_arready;
         h = s_axi_rvalid;
         rd = s_axi_rdata;
         rr = s_axi_rresp;
         @(posedge aclk);
         if (ah) s_axi_arvalid <= 0;
      end
      s_axi_rready <= 0;
   endtask
   // one-cycle pulses are collected over the few cycles after the word is taken
   task automatic ins(input logic [31:0] w);
      g_pc = 0;
      g_gpr = 0;
      g_exc = `EXC_NONE;
      g_we = 0;
      g_wa = 0;
      g_r1 = `EXC_NONE;
      @(posedge aclk);
      instr <= w;
      instr_valid <= 1;
      do @(negedge aclk); while (!instr_ready);
      @(posedge aclk);
      instr_valid <= 0;
      repeat (3) begin
         @(negedge aclk);
         if (redirect) g_pc = redirect_pc;
         if (exc_valid) g_exc = exc_code;
         if (gpr_we) g_gpr = gpr_wdata;
         if (gpr_we) g_wa = gpr_waddr;
         if (r1_exv) g_r1 = r1_exc;
         g_we = g_we | gpr_we;
      end
   endtask
   task automatic link_set();
      @(posedge aclk);
      load_linked_set <= 1;
      @(posedge aclk);
      load_linked_set <= 0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      aclk = 0;
      forever #2.5 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         report_and_stop();
      end
   end
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
      {instr_valid, hazard_pending, load_linked_set, aresetn} = 0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, instr} = 0;
      s_axi_wstrb = 4'hf;
      seed = 10;
      repeat (10) @(posedge aclk);
      aresetn <= 1;
      axr(`ADDR_STATUS_WORD);
      chk(rd, `STATUS_RESET);
      axr(`ADDR_CONFIGURATION_REG_FIVE);
      chk(rd & 32'h00000010, 32'h00000010);
      axr(8'h40);
      chk(rr, 2'h2);
      axw(8'h40, 32'h0);
      chk(br, 2'h2);
      $display("reset and register map done");
      ins(ei_w(5'h01));
      chk(g_exc, `EXC_CPU);
      chk(g_we, 1'b0);
      for (int k = 0; k < 4; k++) begin
         rt = (k == 0) ? 5'h00 : rnd();
         st = 32'h10000002 | (rnd() & 32'h00000f00);
         axw(`ADDR_STATUS_WORD, st);
         ins(ei_w(rt));
         chk(g_we, rt != 5'h00);
         chk(g_gpr, (rt != 5'h00) ? st : 32'h0);
         chk(g_wa, rt);
         chk(g_r1, `EXC_RI);
         chk(interrupt_enable_bit, 1'b1);
         ins(`EHB_WORD);
         axr(`ADDR_STATUS_WORD);
         chk(rd, st | 32'h1);
      end
      $display("enable interrupts done");
      t = rnd();
      previous_shadow_set = rnd();
      axw(`ADDR_EXCEPTION_PC, t);
      axw(`ADDR_SHADOW_CTL, (32'h3 << 26) | {22'h0, previous_shadow_set, 6'h00});
      axw(`ADDR_STATUS_WORD, 32'h10000002);
      link_set();
      ins(ret_w(1'b0));
      chk(g_pc, {t[31:1], 1'b0});
      chk(instruction_set_mode, t[0]);
      chk(load_linked_flag, 1'b0);
      axr(`ADDR_STATUS_WORD);
      chk(rd, 32'h10000000);
      axr(`ADDR_SHADOW_CTL);
      chk(rd[3:0], previous_shadow_set);
      t = rnd();
      axw(`ADDR_ERROR_PC, t);
      axw(`ADDR_STATUS_WORD, 32'h10000006);
      link_set();
      ins(ret_w(1'b1));
      chk(g_pc, {t[31:1], 1'b0});
      chk(load_linked_flag, 1'b1);
      axr(`ADDR_STATUS_WORD);
      chk(rd, 32'h10000002);
      $display("exception returns done");
      // hazards held for five cycles must stretch the stall past the drain count
      @(posedge aclk);
      instr <= `EHB_WORD;
      instr_valid <= 1;
      hazard_pending <= 1;
      @(posedge aclk);
      instr_valid <= 0;
      @(negedge aclk);
      chk({superscalar_nop_issue, clear_exec_hazards, clear_instr_hazards, issue_stall}, 4'hd);
      chk({r1_ssn, r1_ceh, r1_stall}, 3'h4);
      n = 1;
      do begin
         @(posedge aclk);
         hazard_pending <= (n < 5);
         @(negedge aclk);
         n++;
      end while (!instr_ready);
      chk(n >= 5 + `HAZARD_DRAIN_CYCLES && n <= 8 + `HAZARD_DRAIN_CYCLES, 1'b1);
      $display("barrier done");
      report_and_stop();
   end
endmodule // testbench
bind hazard_barrier_exception_return hbr_props #(.ARCH_REV(ARCH_REV)) chk_i (.aclk, .aresetn,
   .instr, .instr_valid, .instr_ready, .load_linked_set, .gpr_we, .gpr_waddr, .redirect_pc,
   .redirect, .exc_valid, .issue_stall,
   .clear_exec_hazards, .clear_instr_hazards, .superscalar_nop_issue, .load_linked_flag,
   .interrupt_enable_bit);
